// [bench/lsr_master.sv]
// LIN master model that drives the frame layer of the read-back core
module lsr_master (
  // Clock
  input  wire logic       clock_in,
  // Headers and published bytes
  output logic            hdr_valid_out,
  output logic [7:0]      hdr_pid_out,
  output logic            rx_byte_valid_out,
  output logic [7:0]      rx_byte_out,
  output logic            rx_frame_ok_out,
  // Response bytes and pacing
  output logic            tx_ready_out,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_last_in,
  input  wire logic       slow_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle frame layer at time zero
  initial begin
    hdr_valid_out = 1'b0;
    hdr_pid_out = 8'h00;
    rx_byte_valid_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_frame_ok_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  // Protected id: two parity bits over the six id bits
  function automatic logic [7:0] prot_id(input logic [5:0] id);
    prot_id = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  // One header pulse; bad flips a parity bit on purpose
  task automatic header(input logic [5:0] id, input logic bad);
    @(posedge clock_in);
    hdr_valid_out <= 1'b1;
    hdr_pid_out   <= prot_id(id) ^ {bad, 7'h00};
    @(posedge clock_in);
    hdr_valid_out <= 1'b0;
    hdr_pid_out   <= ~hdr_pid_out;
  endtask

  // Published frame; released byte lines show the inverse, not stale data
  task automatic frame(input logic [5:0] id, input logic [7:0] b[8], input int n);
    header(id, 1'b0);
    for (int i = 0; i < n; i++) begin
      rx_byte_valid_out <= 1'b1;
      rx_byte_out       <= b[i];
      @(posedge clock_in);
    end
    rx_byte_valid_out <= 1'b0;
    rx_byte_out       <= ~rx_byte_out;
    rx_frame_ok_out   <= 1'b1;
    @(posedge clock_in);
    rx_frame_ok_out   <= 1'b0;
  endtask

  // Take response bytes, stalling at random when slow; bounded
  task automatic collect(output logic [7:0] got[8], output int n);
    n = 0;
    for (int c = 0; c < 60 && n < 8; c++) begin
      @(posedge clock_in);
      if (tx_valid_in && tx_ready_out) begin
        got[n] = tx_byte_in;
        n++;
        if (tx_last_in) break;
      end
      tx_ready_out <= slow_in ? 1'($urandom_range(1)) : 1'b1;
    end
    tx_ready_out <= 1'b0;
  endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for the LIN read-back command core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] QUICK_ID = 6'h12;
  localparam logic [5:0] SHORT_ID = 6'h05;

  logic                   clock_in = 1'b0;
  logic                   reset_n_in = 1'b0;
  logic                   hdr_valid;
  logic [7:0]             hdr_pid;
  logic                   rx_valid;
  logic [7:0]             rx_byte;
  logic                   rx_ok;
  logic                   tx_ready;
  logic                   tx_valid;
  logic [7:0]             tx_byte;
  logic                   tx_last;
  logic                   abort = 1'b0;
  logic [6:0]             node_addr = 7'h00;
  lsr_pkg::lsr_pos_type   pos = '0;
  lsr_pkg::lsr_stall_type stall = '0;
  logic                   motion_switch_state = 1'b0;
  logic [1:0]             tinfo = 2'h0;
  logic                   bank = 1'b0;
  logic [5:0]             cause = 6'h00;
  logic                   short_coil = 1'b0;
  lsr_pkg::lsr_flags_type flags;
  logic                   otp_rd;
  logic [3:0]             otp_addr;
  logic [7:0]             otp_data = 8'h00;
  logic                   slow = 1'b0;
  logic [7:0]             otp_mem [16];
  int                     mismatches = 0;
  int                     tests_run = 0;

  // ****************
  // Clock, OTP array
  // ****************
  always #10 clock_in = ~clock_in;

  // OTP answers one cycle after the strobe, scrambles otherwise
  always @(posedge clock_in) begin
    otp_data <= otp_rd ? otp_mem[otp_addr] : ~otp_data;
  end

  lsr_core u_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in),
    .hdr_valid_in(hdr_valid), .hdr_pid_in(hdr_pid),
    .rx_byte_valid_in(rx_valid), .rx_byte_in(rx_byte),
    .rx_frame_ok_in(rx_ok), .frame_abort_in(abort),
    .tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
    .tx_byte_out(tx_byte), .tx_last_out(tx_last),
    .node_address_in(node_addr), .quick_status_id_in(QUICK_ID),
    .pos_in(pos), .stall_in(stall), .motion_switch_state_in(motion_switch_state),
    .temperature_info_in(tinfo), .secure_position_bank_select_in(bank),
    .flag_cause_in(cause), .short_coil_in(short_coil), .flags_out(flags),
    .otp_rd_out(otp_rd), .otp_addr_out(otp_addr), .otp_data_in(otp_data)
  );

  lsr_master u_master (
    .clock_in(clock_in), .hdr_valid_out(hdr_valid), .hdr_pid_out(hdr_pid),
    .rx_byte_valid_out(rx_valid), .rx_byte_out(rx_byte),
    .rx_frame_ok_out(rx_ok), .tx_ready_out(tx_ready), .tx_valid_in(tx_valid),
    .tx_byte_in(tx_byte), .tx_last_in(tx_last), .slow_in(slow)
  );

  // ****************
  // Helper tasks
  // ****************
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Expected OTP byte for a slot; slots 5 and 6 move with bank select
  function automatic logic [7:0] otp_exp(input int i, input logic bk);
    return otp_mem[(bk && (i == 5 || i == 6)) ? i + 3 : i];
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Byte count first; a short answer means the wait ran out
  task automatic answer(input logic [7:0] e[8], input int n);
    logic [7:0] g[8];
    int         got;
    u_master.collect(g, got);
    check(8'(got), 8'(n));
    if (n > 0 && got < n) end_sim();
    for (int i = 0; i < got && i < n; i++) check(g[i], e[i]);
  endtask

  // Preparing frame, long or short form
  task automatic prep(input logic [6:0] cmd, input logic lng, input logic [6:0] adr,
                      input logic [7:0] fill);
    logic [7:0] b[8];
    if (lng) begin
      b = '{8'h80, {1'b1, cmd}, {1'b1, adr}, fill, 8'hff, 8'hff, 8'hff, 8'hff};
      u_master.frame(6'h3c, b, 8);
    end else begin
      b = '{0: {1'b1, cmd}, 1: {1'b1, adr}, default: 8'h00};
      u_master.frame(SHORT_ID, b, 2);
    end
  endtask

  task automatic quick_q(input logic [5:0] rep);
    logic [7:0] e[8];
    e = '{0: {motion_switch_state, node_addr}, 1: {rep, tinfo}, default: 8'h00};
    u_master.header(QUICK_ID, 1'b0);
    answer(e, 2);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [5:0] p;
    logic [5:0] s;
    logic [5:0] q;
    logic [7:0] e[8];
    void'($urandom(32'h1583f1b0));
    foreach (otp_mem[i]) otp_mem[i] = 8'($urandom());
    node_addr <= 7'($urandom());
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    check(8'(flags), 8'h00);
    check({7'h00, tx_valid}, 8'h00);
    // Random flag causes, some still present at the query
    q = 6'h00;
    for (int k = 0; k < 4; k++) begin
      p = 6'($urandom());
      s = 6'($urandom());
      slow <= k[0];
      cause <= s | p;
      motion_switch_state <= 1'($urandom());
      tinfo <= 2'($urandom());
      @(posedge clock_in);
      cause <= p;
      @(posedge clock_in);
      // Flags kept alive by the last cause are reported again
      quick_q(s | p | q);
      check(8'(flags), {2'b00, p});
      q = p;
    end
    $display("quick status test done");
    // Open coil clears, short coil survives until part two
    cause <= 6'h00;
    @(posedge clock_in);
    cause <= 6'h08;
    @(posedge clock_in);
    cause <= 6'h00;
    @(posedge clock_in);
    quick_q(p | 6'h08);
    check(8'(flags), 8'h00);
    short_coil <= 1'b1;
    @(posedge clock_in);
    short_coil <= 1'b0;
    @(posedge clock_in);
    quick_q(6'h08);
    check(8'(flags), 8'h08);
    pos <= 43'({$urandom(), $urandom()});
    stall <= 10'($urandom());
    prep(7'h01, 1'b1, node_addr, 8'hff);
    u_master.header(6'h3d, 1'b0);
    answer(e, 0);
    e = '{{1'b1, node_addr}, pos.actual_position[15:8], pos.actual_position[7:0],
          pos.target_position[15:8], pos.target_position[7:0], pos.secure_position[7:0],
          {stall.fullstep_stall_enable, 1'b1, stall.full_duty_flag, pos.secure_position[10:8]},
          {stall.absolute_stall_flag, 2'b00, stall.stall_sample_minimum,
           stall.full_duty_stall_enable, stall.pwm_jitter_enable}};
    u_master.header(6'h3d, 1'b0);
    answer(e, 8);
    check(8'(flags), 8'h00);
    $display("coil and full status test done");
    // OTP read, both methods, both banks
    for (int k = 0; k < 4; k++) begin
      bank <= k[0];
      slow <= k[1];
      prep(7'h02, k[1], node_addr, 8'hff);
      for (int i = 0; i < 8; i++) e[i] = otp_exp(i, k[0]);
      u_master.header(6'h3d, 1'b0);
      answer(e, 8);
    end
    $display("otp read test done");
    // Refused preparing frames drop the pending read
    for (int k = 0; k < 3; k++) begin
      prep(7'h02, 1'b0, node_addr, 8'hff);
      prep(7'h02, k != 0, node_addr ^ {6'h00, k != 1}, (k == 1) ? 8'hfe : 8'hff);
      u_master.header(6'h3d, 1'b0);
      // A malformed long frame is ignored, so the short request still answers
      answer(e, (k == 1) ? 8 : 0);
    end
    u_master.header(QUICK_ID, 1'b1);
    answer(e, 0);
    // Link error right after the header drops the quick answer
    u_master.header(QUICK_ID, 1'b0);
    abort <= 1'b1;
    @(posedge clock_in);
    abort <= 1'b0;
    answer(e, 0);
    $display("refusal test done");
    end_sim();
  end
endmodule

// [inc/lsr_cfg.svh]
// Constants for the LIN status and OTP read-back command block
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
`define LSR_ID_PREP     6'h3c
`define LSR_ID_READ     6'h3d
`define LSR_ID_BANK_BIT 5
`define LSR_APP_CMD     8'h80
`define LSR_CMD_FULL    7'h01
`define LSR_CMD_OTP     7'h02
`define LSR_FILL        8'hff
`define LSR_LEN_QUICK   4'h2
`define LSR_LEN_SHORT   4'h2
`define LSR_LEN_DIAG    4'h8
`define LSR_IDX_FIRST   4'h0
`define LSR_SLOT_FIRST  3'h0
`define LSR_SLOT_LAST   3'h7
`define LSR_SLOT_ALT_LO 3'h5
`define LSR_SLOT_ALT_HI 3'h6
`define LSR_OTP_ALT_LO  4'h8
`define LSR_OTP_ALT_HI  4'h9
`define LSR_STATE_RESET '0
`endif

// [inc/lsr_pkg.sv]
// Types shared by the LIN status and OTP read-back block
package lsr_pkg;
  // Response phase, Gray coded along idle, fetch, send
  typedef enum logic [1:0] {
    LSR_IDLE  = 2'b00,
    LSR_FETCH = 2'b01,
    LSR_SEND  = 2'b11
  } lsr_phase_type;
  // Read selected by the last preparing frame
  typedef enum logic [1:0] {
    LSR_NONE  = 2'b00,
    LSR_OTP   = 2'b01,
    LSR_FULL1 = 2'b11,
    LSR_FULL2 = 2'b10
  } lsr_pend_type;
  // Status flags, ordered as in the quick status byte 2
  typedef struct packed {
    logic supply_reset;
    logic lost_steps;
    logic elec_fault;
    logic undervoltage;
    logic thermal_shutdown;
    logic thermal_warning;
  } lsr_flags_type;
  // Stall settings reported in full-status part two
  typedef struct packed {
    logic       absolute_stall_flag;
    logic [2:0] stall_sample_minimum;
    logic       full_duty_stall_enable;
    logic       pwm_jitter_enable;
    logic [2:0] fullstep_stall_enable;
    logic       full_duty_flag;
  } lsr_stall_type;
  // Positions reported in full-status part two
  typedef struct packed {
    logic [15:0] actual_position;
    logic [15:0] target_position;
    logic [10:0] secure_position;
  } lsr_pos_type;
  // Whole state of the core
  typedef struct packed {
    lsr_phase_type       phase;
    lsr_pend_type        pend;
    logic                quick;
    logic [3:0]          len;
    logic [3:0]          idx;
    logic [7:0][7:0]     tx_buf;
    logic                tx_valid;
    logic [7:0]          tx_byte;
    logic                tx_last;
    logic [5:0]          rx_id;
    logic                rx_id_ok;
    logic [3:0]          rx_cnt;
    logic [7:0][7:0]     rx_buf;
    lsr_flags_type       flags;
    logic                short_cause;
    logic                otp_rd;
    logic [3:0]          otp_addr;
    logic [2:0]          otp_slot;
    logic                cap;
    logic [2:0]          cap_slot;
    logic [2:0]          issue_slot;
    logic                issue_done;
  } lsr_state_type;
endpackage

// [logic/lsr_core.sv]
// LIN quick status, full-status part two and OTP read-back command core
//
// Design decisions made here: the OTP address-and-strobe read port.
`include "lsr_cfg.svh"
module lsr_core (
  // Clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   reset_n_in,
  // Frame layer: headers and master-published bytes
  input  wire logic                   hdr_valid_in,
  input  wire logic [7:0]             hdr_pid_in,
  input  wire logic                   rx_byte_valid_in,
  input  wire logic [7:0]             rx_byte_in,
  input  wire logic                   rx_frame_ok_in,
  input  wire logic                   frame_abort_in,
  // Frame layer: response bytes
  input  wire logic                   tx_ready_in,
  output logic                        tx_valid_out,
  output logic [7:0]                  tx_byte_out,
  output logic                        tx_last_out,
  // Node configuration
  input  wire logic [6:0]             node_address_in,
  input  wire logic [5:0]             quick_status_id_in,
  // Device state
  input  wire lsr_pkg::lsr_pos_type   pos_in,
  input  wire lsr_pkg::lsr_stall_type stall_in,
  input  wire logic                   motion_switch_state_in,
  input  wire logic [1:0]             temperature_info_in,
  input  wire logic                   secure_position_bank_select_in,
  input  wire lsr_pkg::lsr_flags_type flag_cause_in,
  input  wire logic                   short_coil_in,
  // Sticky flags
  output lsr_pkg::lsr_flags_type      flags_out,
  // OTP read port, data valid the cycle after the strobe
  output logic                        otp_rd_out,
  output logic [3:0]                  otp_addr_out,
  input  wire logic [7:0]             otp_data_in
);

  // ****************************************
  // Helpers
  // ****************************************

  // Protected identifier from a six-bit frame identifier
  function automatic logic [7:0] lsr_pid(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  // OTP address for a response slot
  function automatic logic [3:0] otp_map(input logic [2:0] slot, input logic bank);
    logic [3:0] a;
    a = {1'b0, slot};
    if (bank && slot == `LSR_SLOT_ALT_LO) begin
      a = `LSR_OTP_ALT_LO;
    end else if (bank && slot == `LSR_SLOT_ALT_HI) begin
      a = `LSR_OTP_ALT_HI;
    end
    return a;
  endfunction

  // ****************************************
  // Decode
  // ****************************************

  lsr_pkg::lsr_state_type r;
  lsr_pkg::lsr_state_type n;
  lsr_pkg::lsr_flags_type clr_mask;
  lsr_pkg::lsr_flags_type set_mask;
  logic                   pid_ok;
  logic                   hdr_go;
  logic                   read_go;
  logic                   quick_go;
  logic                   full_go;
  logic                   fill_ok;
  logic                   prep_long;
  logic                   prep_short;
  logic                   prep_go;
  logic [6:0]             prep_cmd;
  logic [6:0]             prep_addr;
  logic                   tx_take;

  // Header checks; headers are only served while idle
  assign pid_ok   = hdr_pid_in == lsr_pid(hdr_pid_in[5:0]);
  assign hdr_go   = hdr_valid_in && pid_ok && r.phase == lsr_pkg::LSR_IDLE;
  assign read_go  = hdr_go && hdr_pid_in[5:0] == `LSR_ID_READ;
  assign quick_go = hdr_go && !hdr_pid_in[`LSR_ID_BANK_BIT] &&
                    hdr_pid_in[5:0] == quick_status_id_in;
  assign full_go  = read_go && r.pend == lsr_pkg::LSR_FULL2;

  // Preparing frame recognition, long and short form
  assign fill_ok    = r.rx_buf[7:3] == {5{`LSR_FILL}};
  assign prep_long  = r.rx_id == `LSR_ID_PREP && r.rx_cnt == `LSR_LEN_DIAG &&
                      r.rx_buf[0] == `LSR_APP_CMD && r.rx_buf[1][7] &&
                      r.rx_buf[2][7] && fill_ok;
  assign prep_short = !r.rx_id[`LSR_ID_BANK_BIT] && r.rx_id != quick_status_id_in &&
                      r.rx_cnt == `LSR_LEN_SHORT && r.rx_buf[0][7] &&
                      r.rx_buf[1][7];
  assign prep_cmd   = prep_long ? r.rx_buf[1][6:0] : r.rx_buf[0][6:0];
  assign prep_addr  = prep_long ? r.rx_buf[2][6:0] : r.rx_buf[1][6:0];
  assign prep_go    = rx_frame_ok_in && r.rx_id_ok && (prep_long || prep_short);
  assign tx_take    = r.tx_valid && tx_ready_in;

  // ****************************************
  // Next state
  // ****************************************

  // Whole next state in one process
  always_comb begin
    n = r;
    clr_mask = '0;
    set_mask = flag_cause_in;
    set_mask.elec_fault = flag_cause_in.elec_fault || short_coil_in;

    // Collect master-published frame bytes
    if (hdr_valid_in) begin
      n.rx_id = hdr_pid_in[5:0];
      n.rx_id_ok = pid_ok;
      n.rx_cnt = `LSR_IDX_FIRST;
    end else if (rx_byte_valid_in && r.rx_cnt < `LSR_LEN_DIAG) begin
      n.rx_buf[r.rx_cnt[2:0]] = rx_byte_in;
      n.rx_cnt = r.rx_cnt + 4'h1;
    end

    // A preparing frame for another node silences the next read
    if (prep_go) begin
      n.rx_id_ok = 1'b0;
      n.pend = lsr_pkg::LSR_NONE;
      if (prep_addr == node_address_in && prep_cmd == `LSR_CMD_OTP) begin
        n.pend = lsr_pkg::LSR_OTP;
      end else if (prep_addr == node_address_in && prep_cmd == `LSR_CMD_FULL) begin
        n.pend = lsr_pkg::LSR_FULL1;
      end
    end

    // OTP read pipeline: strobe, then capture one cycle later
    n.otp_rd = 1'b0;
    n.cap = r.otp_rd;
    n.cap_slot = r.otp_slot;

    case (r.phase)
      lsr_pkg::LSR_IDLE: begin
        n.tx_valid = 1'b0;
        n.tx_last = 1'b0;
        if (quick_go) begin
          n.tx_buf[0] = {motion_switch_state_in, node_address_in};
          n.tx_buf[1] = {r.flags, temperature_info_in};
          n.quick = 1'b1;
          n.len = `LSR_LEN_QUICK;
          n.phase = lsr_pkg::LSR_SEND;
          n.tx_valid = 1'b1;
          n.idx = `LSR_IDX_FIRST;
          n.tx_byte = n.tx_buf[0];
          // Cleared while reporting, so an event after the snapshot stays
          clr_mask = '1;
          clr_mask.elec_fault = !r.short_cause;
        end else if (read_go) begin
          case (r.pend)
            lsr_pkg::LSR_OTP: begin
              n.pend = lsr_pkg::LSR_NONE;
              n.quick = 1'b0;
              n.len = `LSR_LEN_DIAG;
              n.phase = lsr_pkg::LSR_FETCH;
              n.issue_slot = `LSR_SLOT_FIRST;
              n.issue_done = 1'b0;
            end
            lsr_pkg::LSR_FULL1: begin
              // The first full-status answer belongs to another block
              n.pend = lsr_pkg::LSR_FULL2;
            end
            lsr_pkg::LSR_FULL2: begin
              n.pend = lsr_pkg::LSR_NONE;
              n.tx_buf[0] = {1'b1, node_address_in};
              n.tx_buf[1] = pos_in.actual_position[15:8];
              n.tx_buf[2] = pos_in.actual_position[7:0];
              n.tx_buf[3] = pos_in.target_position[15:8];
              n.tx_buf[4] = pos_in.target_position[7:0];
              n.tx_buf[5] = pos_in.secure_position[7:0];
              n.tx_buf[6] = {stall_in.fullstep_stall_enable, 1'b1,
                             stall_in.full_duty_flag, pos_in.secure_position[10:8]};
              n.tx_buf[7] = {stall_in.absolute_stall_flag, 2'b00,
                             stall_in.stall_sample_minimum,
                             stall_in.full_duty_stall_enable,
                             stall_in.pwm_jitter_enable};
              n.quick = 1'b0;
              n.len = `LSR_LEN_DIAG;
              n.phase = lsr_pkg::LSR_SEND;
              n.tx_valid = 1'b1;
              n.idx = `LSR_IDX_FIRST;
              n.tx_byte = n.tx_buf[0];
              clr_mask.elec_fault = 1'b1;
            end
            default: begin
              n.pend = lsr_pkg::LSR_NONE;
            end
          endcase
        end
      end
      lsr_pkg::LSR_FETCH: begin
        // One OTP address a cycle, bank select chosen per slot
        if (!r.issue_done) begin
          n.otp_rd = 1'b1;
          n.otp_addr = otp_map(r.issue_slot, secure_position_bank_select_in);
          n.otp_slot = r.issue_slot;
          if (r.issue_slot == `LSR_SLOT_LAST) begin
            n.issue_done = 1'b1;
          end else begin
            n.issue_slot = r.issue_slot + 3'h1;
          end
        end
        if (r.cap) begin
          n.tx_buf[r.cap_slot] = otp_data_in;
          if (r.cap_slot == `LSR_SLOT_LAST) begin
            n.phase = lsr_pkg::LSR_SEND;
            n.tx_valid = 1'b1;
            n.idx = `LSR_IDX_FIRST;
            n.tx_byte = n.tx_buf[0];
          end
        end
      end
      lsr_pkg::LSR_SEND: begin
        if (tx_take) begin
          if (r.idx == r.len - 4'h1) begin
            n.phase = lsr_pkg::LSR_IDLE;
            n.tx_valid = 1'b0;
            n.tx_last = 1'b0;
          end else begin
            n.idx = r.idx + 4'h1;
            n.tx_byte = r.tx_buf[n.idx[2:0]];
            n.tx_last = n.idx == r.len - 4'h1;
          end
        end
      end
      default: begin
        n.phase = lsr_pkg::LSR_IDLE;
      end
    endcase

    // A broken frame drops the answer; the flags are already settled
    if (frame_abort_in) begin
      n.phase = lsr_pkg::LSR_IDLE;
      n.tx_valid = 1'b0;
      n.tx_last = 1'b0;
      n.otp_rd = 1'b0;
      n.cap = 1'b0;
    end

    // Sticky flags: a live cause wins over the clear
    n.flags = (r.flags & ~clr_mask) | set_mask;
    n.short_cause = (r.short_cause && !full_go) || short_coil_in;
  end

  // ****************************************
  // State register and outputs
  // ****************************************

  // Single state register, synchronous reset
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      r <= `LSR_STATE_RESET;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign tx_valid_out = r.tx_valid;
  assign tx_byte_out  = r.tx_byte;
  assign tx_last_out  = r.tx_last;
  assign flags_out    = r.flags;
  assign otp_rd_out   = r.otp_rd;
  assign otp_addr_out = r.otp_addr;

  // ****************************************
  // Assertions
  // ****************************************

  // Bad parity never starts an answer
  AST_PARITY_GATE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (hdr_valid_in && !pid_ok && r.phase == lsr_pkg::LSR_IDLE && !rx_frame_ok_in)
    |=> (r.phase == lsr_pkg::LSR_IDLE && !tx_valid_out))
    else $error("answer started on a bad parity header");

  // Quick status first byte carries switch and address
  AST_QUICK_FIRST: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (quick_go && !frame_abort_in) |=> (tx_valid_out &&
    tx_byte_out == {$past(motion_switch_state_in), $past(node_address_in)}))
    else $error("quick status first byte wrong");

  // Quick status ends on its second byte
  AST_QUICK_LEN: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (tx_valid_out && r.quick) |-> (tx_last_out == (r.idx == `LSR_LEN_QUICK - 4'h1)))
    else $error("quick status length wrong");

  // Diagnostic answers end on their eighth byte
  AST_DIAG_LEN: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (tx_valid_out && !r.quick) |-> (tx_last_out == (r.idx == `LSR_LEN_DIAG - 4'h1)))
    else $error("diagnostic answer length wrong");

  // Reported warning is cleared unless its cause holds
  AST_QUICK_CLEAR: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    quick_go |=> (flags_out.thermal_warning == $past(flag_cause_in.thermal_warning)))
    else $error("warning flag not cleared by quick status");

  // Short-caused fault survives quick status
  AST_SHORT_HOLD: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (quick_go && r.short_cause) |=> flags_out.elec_fault)
    else $error("short fault cleared by quick status");

  // Open-coil-only fault is cleared by quick status
  AST_OPEN_CLEAR: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (quick_go && !r.short_cause && !flag_cause_in.elec_fault && !short_coil_in)
    |=> !flags_out.elec_fault)
    else $error("open coil fault not cleared");

  // No preparing frame, no answer on the reading header
  AST_READ_SILENT: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (read_go && r.pend == lsr_pkg::LSR_NONE && !quick_go) |=> ##[0:2]
    (r.phase == lsr_pkg::LSR_IDLE && !tx_valid_out))
    else $error("answer without a preparing frame");

  // Foreign address leaves nothing pending
  AST_ADDR_MISMATCH: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (prep_go && prep_addr != node_address_in) |=> (r.pend == lsr_pkg::LSR_NONE))
    else $error("preparing frame for another node accepted");

  // Bank select moves slot five to the alternate byte
  AST_OTP_BANK: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (otp_rd_out && r.otp_slot == `LSR_SLOT_ALT_LO) |->
    (otp_addr_out == ($past(secure_position_bank_select_in) ? `LSR_OTP_ALT_LO :
                      {1'b0, `LSR_SLOT_ALT_LO})))
    else $error("secure position bank address wrong");

  // OTP fetch finishes and sends in bounded time
  AST_OTP_FETCH: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (r.phase == lsr_pkg::LSR_FETCH && !$past(r.phase == lsr_pkg::LSR_FETCH))
    |-> ##[1:10] (r.phase != lsr_pkg::LSR_FETCH))
    else $error("OTP fetch did not finish");

endmodule
